// ---- cardbus_regs.svh ----
// reset values and timing counts of the cardbus socket core
`ifndef CARDBUS_REGS_SVH
`define CARDBUS_REGS_SVH

`define CB_NOTICE_CYCLES_DEF 8
`define CB_SLOW_DIV_DEF 4
`define CB_RUN_SETTLE 8'h03
`define CB_CNT_ZERO 8'h00
`define CB_CNT_ONE 8'h01
`define CB_IDLE_AD 32'h0000_0000
`define CB_IDLE_CBE 4'h0
`define CB_IDLE_PAR 1'h0
`define CB_GATE_RST 1'h1
`define CB_CLKRUN_LOW 1'h0
`define CB_CLKRUN_HIGH 1'h1

`endif

// ---- cardbus_pkg.sv ----
// types shared by the cardbus socket core
package cardbus_pkg;

    // ad[31] is the most significant bit, ad[0] the least
    typedef struct packed {
        logic [31:0] ad;
        logic [3:0] cbe;
    } phase_t;

    typedef struct packed {
        logic addr;
        phase_t ph;
    } tx_word_t;

    typedef enum logic [1:0] {
        MODE_FULL = 2'h0,
        MODE_SLOW = 2'h1,
        MODE_STOP = 2'h2
    } clk_mode_t;

    typedef enum logic [3:0] {
        CK_RUN = 4'h1,
        CK_NOTICE = 4'h2,
        CK_SLOW = 4'h4,
        CK_STOP = 4'h8
    } clk_state_t;

    typedef struct packed {
        logic rst_req;
        logic tx_tgl;
        tx_word_t tx_word;
        logic ack_s1;
        logic ack_s2;
        logic perr_s1;
        logic perr_s2;
        logic perr_seen;
        logic perr;
    } sys_state_t;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        clk_mode_t mode_s1;
        clk_mode_t mode_s2;
        logic tgl_s1;
        logic tgl_s2;
        logic ack_tgl;
        logic run_s1;
        logic run_s2;
        logic tgt_s1;
        logic tgt_s2;
        clk_state_t ck;
        logic [7:0] cnt;
        logic [7:0] div;
        logic cclk_en;
        logic run_o;
        logic run_oe;
        phase_t drv;
        logic ad_oe;
        logic tx_on;
        logic par;
        logic par_oe;
        phase_t rx;
        logic rx_chk;
        logic perr_tgl;
    } link_state_t;

endpackage

// ---- cardbus_socket_core.sv ----
// socket-side cardbus clock, reset, address/data and parity logic
//
// How it works
// - address/data, command and parity lines are sampled and driven on the rising card clock; clock-run on every rising link clock edge.
// - the card clock runs at the link clock rate, or slowed, or held low.
// - before slowing or stopping, clock-run is driven high as a notice.
// - card reset puts the address/data and parity sequencer in a known state; the clock sequencer runs on.
// - during card reset the core drives the address/data, command and parity lines low.
// - card reset asserts asynchronously and releases on a clock edge.
// - one shared bus carries the address phase and then data phases.
// - address/data bit 31 is the most significant, bit 0 the least.
// - the four command lanes hold the command, then the byte enables.
// - byte enable n qualifies data byte n of the address/data bus.
// - even parity is formed over the 32 data and 4 command lines.
// - as initiator, parity is driven one card clock after its data.
// - as target, a parity mismatch raises a parity error.
`timescale 1ns/100ps
`include "cardbus_regs.svh"

module cardbus_socket_core #(
    parameter int NOTICE_CYCLES = `CB_NOTICE_CYCLES_DEF,
    parameter int SLOW_DIV = `CB_SLOW_DIV_DEF
) (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic CE_I,
    input wire logic PCLK_I,
    input wire logic CARD_RESET_I,
    input wire cardbus_pkg::clk_mode_t CLK_MODE_I,
    input wire logic TARGET_I,
    input wire logic TX_VALID_I,
    input wire cardbus_pkg::tx_word_t TX_WORD_I,
    output logic TX_READY_O,
    output logic PERR_O,
    output logic CCLK_O,
    output logic CRST_N_O,
    input wire logic CCLKRUN_N_I,
    output logic CCLKRUN_N_O,
    output logic CCLKRUN_N_OE_O,
    input wire cardbus_pkg::phase_t CAD_CBE_I,
    output cardbus_pkg::phase_t CAD_CBE_O,
    output logic CAD_CBE_OE_O,
    input wire logic CPAR_I,
    output logic CPAR_O,
    output logic CPAR_OE_O
);

    localparam logic [7:0] NOTICE_LAST = 8'(NOTICE_CYCLES - 1);
    localparam logic [7:0] DIV_LAST = 8'(SLOW_DIV - 1);

    initial
    begin
        if (NOTICE_CYCLES <= int'(`CB_RUN_SETTLE) || NOTICE_CYCLES > 255)
        begin
            $error("NOTICE_CYCLES out of range");
        end
        if (SLOW_DIV < 2 || SLOW_DIV > 255)
        begin
            $error("SLOW_DIV out of range");
        end
    end

    // even parity over data and command lines
    function automatic logic even_par(input cardbus_pkg::phase_t p);
        even_par = ^{p.ad, p.cbe};
    endfunction

    // disabled byte lanes (enable high) are driven as zero
    function automatic logic [31:0] lane_mask(input logic [3:0] cbe);
        for (int i = 0; i < 4; i++)
        begin
            lane_mask[i * 8 +: 8] = {8{~cbe[i]}};
        end
    endfunction

    cardbus_pkg::sys_state_t s;
    cardbus_pkg::sys_state_t next_s;
    cardbus_pkg::link_state_t q;
    cardbus_pkg::link_state_t next_q;
    logic gate;
    logic crst_n;
    logic crst_arst_n;
    logic tick;

    // ---------------- system clock domain ----------------

    always_comb
    begin
        next_s = s;
        next_s.rst_req = CARD_RESET_I;
        next_s.ack_s1 = q.ack_tgl;
        next_s.ack_s2 = s.ack_s1;
        next_s.perr_s1 = q.perr_tgl;
        next_s.perr_s2 = s.perr_s1;
        next_s.perr_seen = s.perr_s2;
        next_s.perr = s.perr_s2 ^ s.perr_seen;
        if (TX_VALID_I && TX_READY_O)
        begin
            // word stays still until the link hands back the toggle
            next_s.tx_word = TX_WORD_I;
            next_s.tx_tgl = ~s.tx_tgl;
        end
    end

    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            s <= '0;
        end
        else if (CE_I)
        begin
            s <= next_s;
        end
    end

    assign TX_READY_O = (s.tx_tgl == s.ack_s2) && !s.rst_req;
    assign PERR_O = s.perr;

    // ---------------- link clock domain ----------------

    // a card clock rising edge happens on this link edge
    assign tick = gate;

    always_comb
    begin
        next_q = q;
        next_q.rst_s1 = s.rst_req;
        next_q.rst_s2 = q.rst_s1;
        next_q.mode_s1 = CLK_MODE_I;
        next_q.mode_s2 = q.mode_s1;
        next_q.tgl_s1 = s.tx_tgl;
        next_q.tgl_s2 = q.tgl_s1;
        next_q.run_s1 = CCLKRUN_N_I;
        next_q.run_s2 = q.run_s1;
        next_q.tgt_s1 = TARGET_I;
        next_q.tgt_s2 = q.tgt_s1;

        case (q.ck)
            cardbus_pkg::CK_RUN:
            begin
                next_q.run_oe = 1'b1;
                next_q.run_o = `CB_CLKRUN_LOW;
                if (q.mode_s2 != cardbus_pkg::MODE_FULL)
                begin
                    // drive clock-run high to announce the slowdown
                    next_q.ck = cardbus_pkg::CK_NOTICE;
                    next_q.run_o = `CB_CLKRUN_HIGH;
                    next_q.cnt = `CB_CNT_ZERO;
                end
            end
            cardbus_pkg::CK_NOTICE:
            begin
                next_q.run_oe = 1'b0;
                next_q.cnt = q.cnt + `CB_CNT_ONE;
                // synchroniser still holds our own low for a few cycles
                if (q.cnt >= `CB_RUN_SETTLE && q.run_s2 == `CB_CLKRUN_LOW)
                begin
                    next_q.ck = cardbus_pkg::CK_RUN;
                end
                else if (q.mode_s2 == cardbus_pkg::MODE_FULL)
                begin
                    next_q.ck = cardbus_pkg::CK_RUN;
                end
                else if (q.cnt == NOTICE_LAST)
                begin
                    next_q.div = `CB_CNT_ZERO;
                    if (q.mode_s2 == cardbus_pkg::MODE_STOP)
                    begin
                        next_q.ck = cardbus_pkg::CK_STOP;
                    end
                    else
                    begin
                        next_q.ck = cardbus_pkg::CK_SLOW;
                    end
                end
            end
            cardbus_pkg::CK_SLOW:
            begin
                next_q.run_oe = 1'b0;
                next_q.div = (q.div == DIV_LAST) ? `CB_CNT_ZERO
                                                 : q.div + `CB_CNT_ONE;
                // card asks for the full rate
                if (q.run_s2 == `CB_CLKRUN_LOW
                    || q.mode_s2 == cardbus_pkg::MODE_FULL)
                begin
                    next_q.ck = cardbus_pkg::CK_RUN;
                end
                else if (q.mode_s2 == cardbus_pkg::MODE_STOP)
                begin
                    // a further decrease is announced again
                    next_q.ck = cardbus_pkg::CK_NOTICE;
                    next_q.run_oe = 1'b1;
                    next_q.run_o = `CB_CLKRUN_HIGH;
                    next_q.cnt = `CB_CNT_ZERO;
                end
            end
            cardbus_pkg::CK_STOP:
            begin
                next_q.run_oe = 1'b0;
                // card asks for the clock back
                if (q.run_s2 == `CB_CLKRUN_LOW
                    || q.mode_s2 != cardbus_pkg::MODE_STOP)
                begin
                    next_q.ck = cardbus_pkg::CK_RUN;
                end
            end
            default:
            begin
                next_q.ck = cardbus_pkg::CK_RUN;
            end
        endcase

        // full rate, one pulse in SLOW_DIV, or held low
        // keep the clock alive while a reset release is pending
        next_q.cclk_en = q.rst_s2 || !crst_n
            || next_q.ck == cardbus_pkg::CK_RUN
            || next_q.ck == cardbus_pkg::CK_NOTICE
            || (next_q.ck == cardbus_pkg::CK_SLOW
                && next_q.div == `CB_CNT_ZERO);

        if (!crst_n)
        begin
            // sequencer parked in a known state
            // card lines held at valid levels by the socket
            next_q.drv.ad = `CB_IDLE_AD;
            next_q.drv.cbe = `CB_IDLE_CBE;
            next_q.ad_oe = 1'b1;
            next_q.tx_on = 1'b0;
            next_q.par = `CB_IDLE_PAR;
            next_q.par_oe = 1'b1;
            next_q.rx_chk = 1'b0;
            next_q.ack_tgl = q.tgl_s2;
        end
        else if (tick)
        begin
            // parity of the previous phase, one card clock later
            next_q.par = even_par(q.drv);
            next_q.par_oe = q.tx_on;
            next_q.tx_on = 1'b0;
            if (q.tgl_s2 != q.ack_tgl)
            begin
                // address or data phase on the shared lines
                // command lanes carry command or byte enables
                next_q.drv.cbe = s.tx_word.ph.cbe;
                if (s.tx_word.addr)
                begin
                    next_q.drv.ad = s.tx_word.ph.ad;
                end
                else
                begin
                    next_q.drv.ad = s.tx_word.ph.ad
                                    & lane_mask(s.tx_word.ph.cbe);
                end
                next_q.tx_on = 1'b1;
                next_q.ack_tgl = q.tgl_s2;
            end
            next_q.ad_oe = next_q.tx_on;
            // target capture on the card clock edge
            next_q.rx = CAD_CBE_I;
            next_q.rx_chk = q.tgt_s2 && !next_q.tx_on;
            // compare with the initiator parity one clock later
            if (q.rx_chk && CPAR_I != even_par(q.rx))
            begin
                next_q.perr_tgl = ~q.perr_tgl;
            end
        end
    end

    always_ff @(posedge PCLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            q <= '0;
            q.ck <= cardbus_pkg::CK_RUN;
            q.mode_s1 <= cardbus_pkg::MODE_FULL;
            q.mode_s2 <= cardbus_pkg::MODE_FULL;
            q.run_s1 <= `CB_CLKRUN_HIGH;
            q.run_s2 <= `CB_CLKRUN_HIGH;
            q.cclk_en <= `CB_GATE_RST;
            q.ad_oe <= 1'b1;
            q.par_oe <= 1'b1;
        end
        else
        begin
            q <= next_q;
        end
    end

    // gate changes only while the link clock is low: no runt pulses
    always_ff @(negedge PCLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            gate <= `CB_GATE_RST;
        end
        else
        begin
            gate <= q.cclk_en;
        end
    end

    // card clock is the link clock, gated low when stopped and between slow pulses
    assign CCLK_O = PCLK_I & gate;

    assign crst_arst_n = NRST_I & ~s.rst_req;

    always_ff @(posedge PCLK_I or negedge crst_arst_n)
    begin
        if (!crst_arst_n)
        begin
            crst_n <= 1'b0;
        end
        // release on a live card clock edge after the sync stage
        else if (tick && !q.rst_s2)
        begin
            crst_n <= 1'b1;
        end
    end

    assign CRST_N_O = crst_n;
    assign CCLKRUN_N_O = q.run_o;
    assign CCLKRUN_N_OE_O = q.run_oe;
    assign CAD_CBE_O = q.drv;
    assign CAD_CBE_OE_O = q.ad_oe;
    assign CPAR_O = q.par;
    assign CPAR_OE_O = q.par_oe;

endmodule

// ---- cardbus_socket_core_asserts.sv ----
// assertions on the cardbus socket core ports
`timescale 1ns/100ps
module cardbus_socket_core_asserts (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic CE_I,
    input wire logic PCLK_I,
    input wire logic CARD_RESET_I,
    input wire logic TX_VALID_I,
    input wire logic TX_READY_O,
    input wire logic PERR_O,
    input wire logic CRST_N_O,
    input wire logic CCLKRUN_N_O,
    input wire logic CCLKRUN_N_OE_O,
    input wire cardbus_pkg::phase_t CAD_CBE_O,
    input wire logic CAD_CBE_OE_O,
    input wire logic CPAR_O,
    input wire logic CPAR_OE_O
);
    a_ready_drop: assert property (@(posedge CLK_I)
        disable iff (!NRST_I) CE_I && TX_VALID_I && TX_READY_O
        |=> !TX_READY_O) else $error("ready held after take");
    a_tx_shows: assert property (@(posedge CLK_I)
        disable iff (!NRST_I) CE_I && TX_VALID_I && TX_READY_O && CRST_N_O
        |-> ##[1:40] CAD_CBE_OE_O) else $error("taken word never driven");
    a_perr_once: assert property (@(posedge CLK_I)
        disable iff (!NRST_I) PERR_O |=> !PERR_O)
        else $error("parity error longer than one cycle");
    a_rst_assert: assert property (@(posedge CLK_I)
        disable iff (!NRST_I) CARD_RESET_I |-> ##[0:2] !CRST_N_O)
        else $error("card reset late");
    a_rst_drive: assert property (@(posedge PCLK_I)
        disable iff (!NRST_I) !CRST_N_O && !$past(CRST_N_O)
        |-> CAD_CBE_OE_O && CPAR_OE_O && CAD_CBE_O == 36'h0 && !CPAR_O)
        else $error("lines not held low in card reset");
    a_par_even: assert property (@(posedge PCLK_I)
        disable iff (!NRST_I) $rose(CPAR_OE_O) && CRST_N_O
        |-> CPAR_O == ^$past(CAD_CBE_O)) else $error("parity not even");
    a_par_late: assert property (@(posedge PCLK_I)
        disable iff (!NRST_I) $rose(CPAR_OE_O) && CRST_N_O
        |-> $past(CAD_CBE_OE_O) && !CAD_CBE_OE_O) else $error("parity slot");
    a_notice_drop: assert property (@(posedge PCLK_I)
        disable iff (!NRST_I) CCLKRUN_N_OE_O && CCLKRUN_N_O
        |=> !CCLKRUN_N_OE_O) else $error("notice held too long");
endmodule

bind cardbus_socket_core cardbus_socket_core_asserts
    cardbus_socket_core_asserts_i (.*);

// ---- cardbus_card_model.sv ----
// card model: moving data stream, even parity, clock-run requests
`timescale 1ns/100ps
module cardbus_card_model (
    input wire logic cclk_i,
    input wire logic bad_i,
    input wire logic fast_i,
    output cardbus_pkg::phase_t cad_o,
    output logic cpar_o,
    output logic pull_o
);
    assign pull_o = fast_i;
    initial cad_o = 36'h5a5a_50f0f;
    // floating lines never hold a level
    always @(posedge cclk_i)
    begin
        cad_o <= {cad_o[34:0], ~cad_o[35]};
        // parity trails its data by one card clock
        cpar_o <= ^cad_o ^ bad_i;
    end
endmodule

// ---- test_cardbus_socket_core.sv ----
// self-checking bench for the cardbus socket core
`timescale 1ns/100ps
module test_cardbus_socket_core;
    localparam int SLOW = 2;
    logic clk = 1'h0;
    logic pclk = 1'h0;
    logic nrst = 1'h0;
    logic crq = 1'h0;
    logic tgt = 1'h0;
    logic tv = 1'h0;
    logic bad = 1'h0;
    logic fast = 1'h0;
    cardbus_pkg::clk_mode_t mode = cardbus_pkg::MODE_FULL;
    cardbus_pkg::tx_word_t tw = 37'h0;
    cardbus_pkg::phase_t cad, cad_c;
    logic rdy, perr, cclk, crst_n, run, run_oe, cad_oe, par, par_oe;
    logic par_c, pull;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    // pulled up; either side may pull it low
    wire logic run_pin = !(run_oe && !run) && !pull;
    initial
    begin
        forever #50 clk = ~clk;
    end
    initial
    begin
        #37;
        forever #80 pclk = ~pclk;
    end
    cardbus_socket_core #(.NOTICE_CYCLES(4), .SLOW_DIV(SLOW))
        cardbus_socket_core_i (
        .CLK_I(clk), .NRST_I(nrst), .CE_I(1'h1), .PCLK_I(pclk),
        .CARD_RESET_I(crq), .CLK_MODE_I(mode), .TARGET_I(tgt),
        .TX_VALID_I(tv), .TX_WORD_I(tw), .TX_READY_O(rdy), .PERR_O(perr),
        .CCLK_O(cclk), .CRST_N_O(crst_n), .CCLKRUN_N_I(run_pin),
        .CCLKRUN_N_O(run), .CCLKRUN_N_OE_O(run_oe),
        .CAD_CBE_I(cad_oe ? cad : cad_c), .CAD_CBE_O(cad),
        .CAD_CBE_OE_O(cad_oe), .CPAR_I(par_oe ? par : par_c),
        .CPAR_O(par), .CPAR_OE_O(par_oe));
    cardbus_card_model cardbus_card_model_i (.cclk_i(cclk), .bad_i(bad),
        .fast_i(fast), .cad_o(cad_c), .cpar_o(par_c), .pull_o(pull));
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // sample once the link registers have moved
    task automatic pedge(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // a release off the rising card clock shows pclk high
    task automatic wait_rel();
        int n;
        n = 0;
        while (crst_n !== 1'h1 && n < 60)
        begin
            @(pclk or crst_n);
            n++;
        end
        chk({34'h0, pclk, crst_n}, 36'h3);
    endtask
    task automatic count_hi(input int want);
        int n;
        n = 0;
        repeat (16)
        begin
            pedge(1);
            n += (cclk === 1'h1) ? 1 : 0;
        end
        chk(36'(n), 36'(want));
    endtask
    task automatic t_reset();
        repeat (3) @(posedge clk);
        chk({33'h0, crst_n, cad_oe, par_oe}, 36'h3);
        nrst <= 1'h1;
        wait_rel();
        pedge(3);
        chk({32'h0, crst_n, cad_oe, run_oe, run}, 36'ha);
    endtask
    task automatic t_tx(input cardbus_pkg::tx_word_t w);
        cardbus_pkg::phase_t e;
        int n;
        e = w.ph;
        for (n = 0; n < 4; n++)
            if (!w.addr && w.ph.cbe[n])
                e.ad[8*n +: 8] = 8'h00;
        @(posedge clk);
        chk({35'h0, rdy}, 36'h1);
        tw <= w;
        tv <= 1'h1;
        @(posedge clk);
        tv <= 1'h0;
        n = 0;
        while (cad_oe !== 1'h1 && n < 40)
        begin
            pedge(1);
            n++;
        end
        chk(cad, e);
        pedge(1);
        chk({33'h0, par_oe, par, cad_oe}, {34'h1, ^e, 1'h0});
        n = 0;
        while (rdy !== 1'h1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic t_perr();
        int n;
        int k;
        @(posedge clk);
        tgt <= 1'h1;
        for (k = 0; k < 2; k++)
        begin
            n = 0;
            repeat (24)
            begin
                @(negedge clk);
                n += (perr === 1'h1) ? 1 : 0;
            end
            chk(36'(n), 36'(k));
            @(posedge cclk);
            bad <= 1'h1;
            @(posedge cclk);
            bad <= 1'h0;
        end
        @(posedge clk);
        tgt <= 1'h0;
    endtask
    task automatic t_slow();
        int n;
        logic seen;
        seen = 1'h0;
        n = 0;
        @(posedge clk);
        mode <= cardbus_pkg::MODE_SLOW;
        do
        begin
            pedge(1);
            seen |= run_oe & run;
            n++;
        end
        while (cclk !== 1'h0 && n < 40);
        chk({35'h0, seen}, 36'h1);
        count_hi(16 / SLOW);
        // mode stays slow: only the card's request can bring the clock back
        @(posedge clk);
        fast <= 1'h1;
        pedge(8);
        count_hi(16);
        @(posedge clk);
        fast <= 1'h0;
        mode <= cardbus_pkg::MODE_STOP;
        pedge(24);
        count_hi(0);
        @(posedge clk);
        mode <= cardbus_pkg::MODE_FULL;
        fast <= 1'h1;
        pedge(8);
        count_hi(16);
        fast <= 1'h0;
    endtask
    task automatic t_crst();
        @(posedge clk);
        crq <= 1'h1;
        repeat (2) @(negedge clk);
        chk({35'h0, crst_n}, 36'h0);
        pedge(2);
        chk({33'h0, rdy, cad_oe, par_oe}, 36'h3);
        @(posedge clk);
        crq <= 1'h0;
        wait_rel();
        pedge(3);
    endtask
    initial
    begin
        t_reset();
        t_tx({1'h1, 32'h8000_0001, 4'h7});
        for (int k = 0; k < 16; k += 5)
            t_tx({1'h0, 32'hc3a5_5a3c, k[3:0]});
        t_perr();
        t_slow();
        t_crst();
        t_tx({1'h0, 32'h0102_0304, 4'h9});
        tally_and_finish();
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            $display("[ERR] %0t timeout", $time);
            tally_and_finish();
        end
    end
endmodule
